// ==== hw/asr_pkg.sv ====
/*
  Constants for the audio serial port with sample-rate and clock-divider control:
  register offsets, field positions, reset values, rate periods and converter latencies.
  Assumes a single core clock; all users refer to names as asr_pkg::name.
*/
package asr_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STAT = 5'h04;
  localparam logic [4:0] ADDR_SRATE = 5'h08;
  localparam logic [4:0] ADDR_REC_L = 5'h0C;
  localparam logic [4:0] ADDR_REC_R = 5'h10;
  localparam logic [4:0] ADDR_PB_L = 5'h14;
  localparam logic [4:0] ADDR_PB_R = 5'h18;
  // Interface control fields
  localparam int CTL_ACT = 0;
  localparam int CTL_MASTER = 1;
  localparam int CTL_FMT_LO = 2;
  localparam int CTL_WL_LO = 4;
  localparam int CTL_LRP = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // sample_rate_clock_setup fields
  localparam int SR_USB = 0;
  localparam int SR_OVERSAMPLE_BASE_SEL = 1;
  localparam int SR_CODE_LO = 2;
  localparam int SR_CORE_HALF = 6;
  localparam int SR_PIN_HALF = 7;
  localparam logic [8:0] SRATE_RST = 9'h020;
  // Framing modes
  localparam logic [1:0] FMT_RJ = 2'h0;
  localparam logic [1:0] FMT_LJ = 2'h1;
  localparam logic [1:0] FMT_I2S = 2'h2;
  localparam logic [1:0] FMT_DSP = 2'h3;
  // Master clock periods per sample, USB mode (12 MHz)
  localparam logic [11:0] P_USB_96 = 12'h07D;
  localparam logic [11:0] P_USB_882 = 12'h088;
  localparam logic [11:0] P_USB_48 = 12'h0FA;
  localparam logic [11:0] P_USB_441 = 12'h110;
  localparam logic [11:0] P_USB_32 = 12'h177;
  localparam logic [11:0] P_USB_8021 = 12'h5D8;
  localparam logic [11:0] P_USB_8 = 12'h5DC;
  // Normal-mode base oversampling
  localparam logic [11:0] BASE_256 = 12'h100;
  localparam logic [11:0] BASE_384 = 12'h180;
  // Bit clock half period minus one, in master clock edges, normal mode at low rates
  localparam logic [1:0] BDIV_SLOW = 2'h3;
  // Group delays in sample periods, filter types 0..3
  localparam logic [19:0] DAC_LAT = {5'h05, 5'h05, 5'h12, 5'h0B};
  localparam logic [19:0] ADC_LAT = {5'h06, 5'h03, 5'h14, 5'h0C};
  // Bus handshake states
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} asr_bus_t;
endpackage : asr_pkg

// ==== hw/asr_core.sv ====
/*
  Audio serial port with sample-rate generator, bit/frame clock generation and
  clock dividers, reached over an Avalon-MM slave with waitrequest.
  Assumes MCLK_EDGE pulses once per master clock edge, synchronous to SYS_CLK,
  and that slave-mode pins are already synchronous to SYS_CLK.
*/
`timescale 1ns/100ps
module asr_core (
  // Clock, reset, freeze
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  // Avalon-MM register slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Master clock edge strobe and divided clock pin
  input wire logic MCLK_EDGE,
  output logic OUT_CLK_PIN,
  // Bit clock pin
  input wire logic BCLK_IN,
  output logic BCLK_OUT,
  output logic BCLK_OE,
  // Frame sync pins
  input wire logic PLAYBACK_FRAME_SYNC_IN,
  output logic PLAYBACK_FRAME_SYNC_OUT,
  output logic PLAYBACK_FRAME_SYNC_OE,
  input wire logic RECORD_FRAME_SYNC_IN,
  output logic RECORD_FRAME_SYNC_OUT,
  output logic RECORD_FRAME_SYNC_OE,
  // Serial data
  input wire logic DIN,
  output logic DOUT
);
  asr_pkg::asr_bus_t bus_q;
  logic wait_q, oclk_q, oc_ph_q, bclk_q, bclk_oe_q, bclk_prev_q, dout_q;
  logic [31:0] rdata_q, rd_mux, rec_l_q, rec_r_q, pb_l_q, pb_r_q, sh_q;
  logic [6:0] ctrl_q;
  logic [7:0] srate_q;
  logic [1:0] bc_cnt_q, bdiv, fmt, ftype, lr_q, fs_prev_q, fs_oe_q, pend_q, fs_lvl;
  logic [12:0] hf_cnt_q [2];
  logic [12:0] half_ticks [2];
  logic [6:0] bit_q [2];
  logic [6:0] len_q [2];
  logic [5:0] wl;
  logic [4:0] dac_lat, adc_lat;
  logic act, master, usb, wr_take, tick, bfall, brise;

  // Word length in bits; right-justified cannot use 32, so it falls back to 24
  function automatic logic [5:0] word_bits(input logic [1:0] f, input logic [1:0] c);
    case (c)
      2'h0: word_bits = 6'd16;
      2'h1: word_bits = 6'd20;
      2'h2: word_bits = 6'd24;
      default: word_bits = (f == asr_pkg::FMT_RJ) ? 6'd24 : 6'd32;
    endcase
  endfunction : word_bits

  // Master clock periods per sample for one converter
  function automatic logic [11:0] period(input logic u, input logic bo,
                                         input logic [3:0] c, input logic adc);
    logic [2:0] s;
    logic [11:0] b;
    s = 3'd0;
    b = bo ? asr_pkg::BASE_384 : asr_pkg::BASE_256;
    case (c)
      4'h1: s = adc ? 3'd0 : 3'd1;
      4'h2: s = adc ? 3'd1 : 3'd0;
      4'h3: s = 3'd1;
      4'h6: s = 3'd2;
      4'h7: s = 3'd3;
      4'h8: s = 3'd4;
      4'h9: s = adc ? 3'd4 : 3'd5;
      4'hA: s = adc ? 3'd5 : 3'd4;
      4'hB: s = 3'd5;
      4'hF: s = 3'd6;
      default: s = 3'd0;
    endcase
    // Integer dividers of 12 MHz give 8.021, 44.117 and 88.235 kHz
    if (u) begin
      case (s)
        3'd1: period = asr_pkg::P_USB_8;
        3'd2: period = asr_pkg::P_USB_32;
        3'd3: period = asr_pkg::P_USB_96;
        3'd4: period = asr_pkg::P_USB_441;
        3'd5: period = asr_pkg::P_USB_8021;
        3'd6: period = asr_pkg::P_USB_882;
        default: period = asr_pkg::P_USB_48;
      endcase
    end else begin
      case (s)
        3'd1: period = 12'(b * 6);
        3'd2: period = 12'((b * 3) >> 1);
        3'd3, 3'd6: period = b >> 1;
        3'd5: period = 12'((b * 11) >> 1);
        default: period = b;
      endcase
    end
  endfunction : period

  // Slot of bit k since the frame edge: {valid, right channel, distance from MSB}
  function automatic logic [6:0] slot(input logic [1:0] f, input logic [5:0] w,
                                      input logic [6:0] k, input logic [6:0] h,
                                      input logic lr, input logic lr_phase_sel);
    logic [7:0] s, d;
    logic lft;
    s = 8'd0;
    lft = lr_phase_sel ^ (f != asr_pkg::FMT_I2S);
    case (f)
      asr_pkg::FMT_I2S: s = 8'd1;
      asr_pkg::FMT_RJ: s = (h >= 7'(w)) ? 8'(h - 7'(w)) : 8'd0;
      asr_pkg::FMT_DSP: s = lr_phase_sel ? 8'd0 : 8'd1;
      default: s = 8'd0;
    endcase
    d = 8'(k) - s;
    if (f == asr_pkg::FMT_DSP) begin
      // Right word follows the left one with no gap
      if (8'(k) >= s && d < 8'(w)) slot = {2'b10, d[4:0]};
      else if (8'(k) >= s && d < 8'({w, 1'b0})) slot = {2'b11, 5'(d - 8'(w))};
      else slot = 7'h00;
    end else begin
      slot = {(8'(k) >= s) && (d < 8'(w)), lr != lft, d[4:0]};
    end
  endfunction : slot

  assign act = ctrl_q[asr_pkg::CTL_ACT];
  assign master = ctrl_q[asr_pkg::CTL_MASTER];
  assign fmt = ctrl_q[asr_pkg::CTL_FMT_LO +: 2];
  assign wl = word_bits(fmt, ctrl_q[asr_pkg::CTL_WL_LO +: 2]);
  assign usb = srate_q[asr_pkg::SR_USB];
  assign tick = CE && MCLK_EDGE;
  assign wr_take = CE && (bus_q == asr_pkg::BUS_ACK) && AVS_WRITE;

  // Rate periods, bit clock divider, filter type and latency
  always_comb begin
    half_ticks[0] = 13'(period(usb, srate_q[asr_pkg::SR_OVERSAMPLE_BASE_SEL],
                               srate_q[asr_pkg::SR_CODE_LO +: 4], 1'b0))
                    << srate_q[asr_pkg::SR_CORE_HALF];
    half_ticks[1] = 13'(period(usb, srate_q[asr_pkg::SR_OVERSAMPLE_BASE_SEL],
                               srate_q[asr_pkg::SR_CODE_LO +: 4], 1'b1))
                    << srate_q[asr_pkg::SR_CORE_HALF];
    bdiv = (usb || srate_q[asr_pkg::SR_CODE_LO +: 3] == 3'h7) ? 2'h0 : asr_pkg::BDIV_SLOW;
    if (srate_q[asr_pkg::SR_CODE_LO +: 4] == 4'h7) ftype = usb ? 2'h3 : 2'h2;
    else if (srate_q[asr_pkg::SR_CODE_LO +: 4] == 4'hF) ftype = 2'h2;
    else ftype = usb ? {1'b0, srate_q[asr_pkg::SR_CODE_LO + 3]} : 2'h1;
    dac_lat = asr_pkg::DAC_LAT[5 * ftype +: 5];
    adc_lat = asr_pkg::ADC_LAT[5 * ftype +: 5];
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    case (AVS_ADDRESS)
      asr_pkg::ADDR_CTRL: rd_mux = {25'h0, ctrl_q};
      asr_pkg::ADDR_STAT: rd_mux = {18'h0, bdiv == 2'h0, ftype, adc_lat, dac_lat, 1'b0};
      asr_pkg::ADDR_SRATE: rd_mux = {24'h0, srate_q};
      asr_pkg::ADDR_REC_L: rd_mux = rec_l_q;
      asr_pkg::ADDR_REC_R: rd_mux = rec_r_q;
      asr_pkg::ADDR_PB_L: rd_mux = pb_l_q;
      asr_pkg::ADDR_PB_R: rd_mux = pb_r_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus handshake: every request is answered one cycle after it is seen
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bus_q <= asr_pkg::BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (CE) begin
      case (bus_q)
        asr_pkg::BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_q <= asr_pkg::BUS_ACK;
            wait_q <= 1'b0;
            rdata_q <= AVS_READ ? rd_mux : 32'h0000_0000;
          end
        end
        default: begin
          bus_q <= asr_pkg::BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // Software registers; the reserved top bit is simply not stored
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_q <= asr_pkg::CTRL_RST;
      srate_q <= asr_pkg::SRATE_RST[7:0];
      rec_l_q <= 32'h0000_0000;
      rec_r_q <= 32'h0000_0000;
    end else if (wr_take) begin
      if (AVS_ADDRESS == asr_pkg::ADDR_CTRL) ctrl_q <= AVS_WRITEDATA[6:0];
      if (AVS_ADDRESS == asr_pkg::ADDR_SRATE) srate_q <= AVS_WRITEDATA[7:0];
      if (AVS_ADDRESS == asr_pkg::ADDR_REC_L) rec_l_q <= AVS_WRITEDATA;
      if (AVS_ADDRESS == asr_pkg::ADDR_REC_R) rec_r_q <= AVS_WRITEDATA;
    end
  end

  // Clock pin divider, independent of act and master; SR_PIN_HALF halves its rate
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      oclk_q <= 1'b0;
      oc_ph_q <= 1'b0;
    end else if (tick) begin
      oc_ph_q <= ~oc_ph_q;
      if (!srate_q[asr_pkg::SR_PIN_HALF] || oc_ph_q) oclk_q <= ~oclk_q;
    end
  end

  // Bit clock generator; stops when inactive so the host sees no stray edges
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bclk_q <= 1'b0;
      bc_cnt_q <= 2'h0;
      bclk_oe_q <= 1'b0;
      fs_oe_q <= 2'b00;
    end else if (CE) begin
      bclk_oe_q <= master;
      fs_oe_q <= {master, master};
      if (!(act && master)) begin
        bclk_q <= 1'b0;
        bc_cnt_q <= 2'h0;
      end else if (MCLK_EDGE) begin
        bc_cnt_q <= (bc_cnt_q >= bdiv) ? 2'h0 : 2'(bc_cnt_q + 2'h1);
        if (bc_cnt_q >= bdiv) bclk_q <= ~bclk_q;
      end
    end
  end

  // Frame clocks: a half-frame count arms a toggle taken at the next bit clock fall
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      lr_q <= 2'b00;
      pend_q <= 2'b00;
      for (int i = 0; i < 2; i++) hf_cnt_q[i] <= 13'h0000;
    end else if (CE) begin
      for (int i = 0; i < 2; i++) begin
        if (!(act && master)) begin
          hf_cnt_q[i] <= 13'h0000;
          pend_q[i] <= 1'b0;
        end else begin
          if (pend_q[i] && bclk_q && MCLK_EDGE && bc_cnt_q >= bdiv) begin
            lr_q[i] <= ~lr_q[i];
            pend_q[i] <= 1'b0;
          end
          // A fresh expiry in the same cycle as a toggle must not be lost
          if (MCLK_EDGE) begin
            hf_cnt_q[i] <= (hf_cnt_q[i] + 13'h0001 >= half_ticks[i]) ? 13'h0000
                           : 13'(hf_cnt_q[i] + 13'h0001);
            if (hf_cnt_q[i] + 13'h0001 >= half_ticks[i]) pend_q[i] <= 1'b1;
          end
        end
      end
    end
  end

  assign fs_lvl = master ? lr_q : {RECORD_FRAME_SYNC_IN, PLAYBACK_FRAME_SYNC_IN};
  assign brise = (master ? bclk_q : BCLK_IN) && !bclk_prev_q;
  assign bfall = !(master ? bclk_q : BCLK_IN) && bclk_prev_q;

  // Bit position counters, one per direction; index 0 playback, 1 record
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bclk_prev_q <= 1'b0;
      fs_prev_q <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        bit_q[i] <= 7'h00;
        len_q[i] <= 7'h00;
      end
    end else if (CE) begin
      bclk_prev_q <= master ? bclk_q : BCLK_IN;
      fs_prev_q <= fs_lvl;
      for (int i = 0; i < 2; i++) begin
        if (fs_prev_q[i] && !fs_lvl[i] || fmt != asr_pkg::FMT_DSP
            && !fs_prev_q[i] && fs_lvl[i]) begin
          bit_q[i] <= 7'h00;
          len_q[i] <= bit_q[i];
        end else if (brise && bit_q[i] != 7'h7F) begin
          bit_q[i] <= 7'(bit_q[i] + 7'h01);
        end
      end
    end
  end

  // Playback receive: DIN sampled on bit clock rises, word stored at its LSB
  always_ff @(posedge SYS_CLK) begin : rx_blk
    logic [6:0] sl;
    logic [31:0] wmask;
    sl = slot(fmt, wl, bit_q[0], len_q[0], fs_lvl[0], ctrl_q[asr_pkg::CTL_LRP]);
    // Bits above the word read as zero, not as leftovers of the previous word
    wmask = 32'hFFFF_FFFF >> (6'd32 - wl);
    if (RST) begin
      sh_q <= 32'h0000_0000;
      pb_l_q <= 32'h0000_0000;
      pb_r_q <= 32'h0000_0000;
    end else if (CE && act && brise && sl[6]) begin
      sh_q <= {sh_q[30:0], DIN};
      if (sl[4:0] == 5'(wl - 6'd1) && !sl[5]) pb_l_q <= {sh_q[30:0], DIN} & wmask;
      if (sl[4:0] == 5'(wl - 6'd1) && sl[5]) pb_r_q <= {sh_q[30:0], DIN} & wmask;
    end
  end

  // Record transmit: DOUT changes on bit clock falls, MSB first, low outside a word
  always_ff @(posedge SYS_CLK) begin : tx_blk
    logic [6:0] sl;
    logic [5:0] ix;
    sl = slot(fmt, wl, (fs_prev_q[1] != fs_lvl[1]) ? 7'h00 : bit_q[1], len_q[1],
              fs_lvl[1], ctrl_q[asr_pkg::CTL_LRP]);
    ix = 6'(wl - 6'd1 - {1'b0, sl[4:0]});
    if (RST) begin
      dout_q <= 1'b0;
    end else if (CE) begin
      if (!act) dout_q <= 1'b0;
      else if (bfall) dout_q <= sl[6] && (sl[5] ? rec_r_q[ix[4:0]] : rec_l_q[ix[4:0]]);
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign OUT_CLK_PIN = oclk_q;
  assign BCLK_OUT = bclk_q;
  assign BCLK_OE = bclk_oe_q;
  assign PLAYBACK_FRAME_SYNC_OUT = lr_q[0];
  assign RECORD_FRAME_SYNC_OUT = lr_q[1];
  assign PLAYBACK_FRAME_SYNC_OE = fs_oe_q[0];
  assign RECORD_FRAME_SYNC_OE = fs_oe_q[1];
  assign DOUT = dout_q;

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_req;
    CE && wait_q && (AVS_READ || AVS_WRITE);
  endsequence
  sequence s_ack;
    !AVS_WAITREQUEST ##1 (AVS_WAITREQUEST || !CE);
  endsequence
  chk_bus_answer: assert property (s_req |=> s_ack)
    else $error("bus request not answered in one cycle");
  chk_rsv_reads_zero: assert property (
    (bus_q == asr_pkg::BUS_ACK && AVS_READ && AVS_ADDRESS == asr_pkg::ADDR_SRATE)
    |-> AVS_READDATA[31:8] == 24'h00_0000) else $error("reserved bit read back nonzero");
  chk_bclk_dir: assert property (CE |=> BCLK_OE == $past(master))
    else $error("bit clock direction wrong");
  chk_frame_dir: assert property (
    CE |=> PLAYBACK_FRAME_SYNC_OE == $past(master) && RECORD_FRAME_SYNC_OE == $past(master))
    else $error("frame sync direction wrong");
  chk_idle_silent: assert property ((CE && !act) [*2] |-> !DOUT)
    else $error("data driven while inactive");
  chk_rj_width: assert property (fmt == asr_pkg::FMT_RJ |-> wl <= 6'd24)
    else $error("right-justified word of 32 bits");
  chk_pin_divider: assert property (
    (tick && !srate_q[asr_pkg::SR_PIN_HALF]) |=> OUT_CLK_PIN != $past(OUT_CLK_PIN))
    else $error("clock pin not toggling at master rate");
  chk_bclk_usb: assert property (
    (tick && act && master && usb) |=> BCLK_OUT != $past(BCLK_OUT))
    else $error("USB bit clock not at master rate");
  chk_usb_48k: assert property (
    (usb && !srate_q[asr_pkg::SR_CORE_HALF] && srate_q[5:2] == 4'h0)
    |-> half_ticks[0] == 13'd250 && half_ticks[1] == 13'd250)
    else $error("USB 48 kHz period wrong");
  chk_core_halver: assert property (
    (usb && srate_q[asr_pkg::SR_CORE_HALF] && srate_q[5:2] == 4'h7) |-> half_ticks[0] == 13'd250)
    else $error("core halver did not halve rate");
  chk_latency_map: assert property (
    (usb && srate_q[5:2] == 4'h0) |-> dac_lat == 5'd11 && adc_lat == 5'd12)
    else $error("latency does not match filter type");
endmodule : asr_core

// ==== testbench/asr_host_model.sv ====
/*
  Host serial port model for slave-mode runs: makes bit clock and frame sync,
  sends playback words and captures record bits by slot.
  Assumes the bench runs it only while the codec is a slave.
*/
`timescale 1ns/100ps
module asr_host_model (
  // Clock and setup
  input wire logic clk,
  input wire logic run,
  input wire logic [1:0] fmt,
  input wire logic [5:0] wl,
  input wire logic [31:0] tx_l,
  input wire logic [31:0] tx_r,
  // Link pins
  output logic bclk,
  output logic sync,
  output logic din,
  input wire logic dout,
  // Record bits of the latest frame, one per slot
  output logic [63:0] cap
);
  logic [2:0] ph;
  logic [5:0] slot;
  logic [63:0] used, bits;

  // Slot of each word bit, MSB first, for each framing mode
  function automatic logic [63:0] frame_bits(input logic [1:0] f, input logic [5:0] w,
    input logic [31:0] l, input logic [31:0] r);
    logic [63:0] v;
    int s;
    int n;
    v = '0;
    n = int'(w);
    for (int i = 0; i < n; i++) begin
      s = (f == 2'h1) ? i : (f == 2'h0) ? 32 - n + i : 1 + i;
      v[s] = l[n - 1 - i];
      v[(f == 2'h3) ? s + n : s + 32] = r[n - 1 - i];
    end
    return v;
  endfunction : frame_bits

  // Left level is high when justified, low in I2S; DSP gets a one-slot pulse
  function automatic logic sync_lvl(input logic [1:0] f, input logic [5:0] s);
    case (f)
      2'h2: return s[5];
      2'h3: return s == 6'h3F;
      default: return !s[5];
    endcase
  endfunction : sync_lvl

  // Slots that carry word bits, and those bits, for the current setup
  assign used = frame_bits(fmt, wl, '1, '1);
  assign bits = frame_bits(fmt, wl, tx_l, tx_r);

  // Clock stands still when idle while din toggles; when running, sync and data move only at bit clock falls
  always_ff @(posedge clk) begin
    if (!run) begin
      ph <= 3'h0;
      slot <= 6'h00;
      bclk <= 1'b0;
      sync <= 1'b0;
      din <= (din !== 1'b1); // Released line must not keep a stale level
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h0) begin
        bclk <= 1'b0;
        sync <= sync_lvl(fmt, slot);
        din <= used[slot] ? bits[slot] : (din !== 1'b1);
      end
      if (ph == 3'h4) begin
        bclk <= 1'b1;
      end
      if (ph == 3'h7) begin
        cap[slot] <= dout;
        slot <= slot + 6'h01;
      end
    end
  end
endmodule : asr_host_model

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for the audio serial port: register access over
  Avalon-MM, rate and clock checks as master, word transfer as slave.
  Assumes the host model file is compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, mclk_edge = 1'b0, out_clk_pin;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic bclk_out, bclk_oe, pfs_out, pfs_oe, rfs_out, rfs_oe, dout;
  logic h_bclk, h_sync, h_din, h_run, bclk_w, pfs_w, rfs_w, bclk_p, pin_p, pfs_p;
  logic [1:0] h_fmt;
  logic [5:0] h_wl;
  logic [31:0] h_l, h_r;
  logic [63:0] h_cap, ev;
  int failures, n_checks, cyc, n_edge, n_bt, n_pt, fs_cnt, fs_len, de, db, dp;
  logic [8:0] srv[8] = '{9'h05D, 9'h03F, 9'h001, 9'h023, 9'h01C, 9'h000, 9'h020, 9'h03C};
  int ft[8] = '{3, 2, 0, 1, 2, 1, 1, 2};
  int dac_l[4] = '{11, 18, 5, 5};
  int adc_l[4] = '{12, 20, 3, 6};
  int fm[5] = '{0, 1, 2, 3, 1};
  int wc[5] = '{3, 0, 1, 2, 3};
  int nb[5] = '{24, 16, 20, 24, 32};

  // Pin levels from whichever side drives; the host ties both syncs together
  assign bclk_w = bclk_oe ? bclk_out : h_bclk;
  assign pfs_w = pfs_oe ? pfs_out : h_sync;
  assign rfs_w = rfs_oe ? rfs_out : h_sync;

  asr_core u_dut (.SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .MCLK_EDGE(mclk_edge), .OUT_CLK_PIN(out_clk_pin), .BCLK_IN(bclk_w),
    .BCLK_OUT(bclk_out), .BCLK_OE(bclk_oe), .PLAYBACK_FRAME_SYNC_IN(pfs_w),
    .PLAYBACK_FRAME_SYNC_OUT(pfs_out), .PLAYBACK_FRAME_SYNC_OE(pfs_oe),
    .RECORD_FRAME_SYNC_IN(rfs_w), .RECORD_FRAME_SYNC_OUT(rfs_out),
    .RECORD_FRAME_SYNC_OE(rfs_oe), .DIN(h_din), .DOUT(dout));

  asr_host_model u_host (.clk(sys_clk), .run(h_run), .fmt(h_fmt), .wl(h_wl), .tx_l(h_l),
    .tx_r(h_r), .bclk(h_bclk), .sync(h_sync), .din(h_din), .dout(dout), .cap(h_cap));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Master clock strobe every other cycle, edge counters and the hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    mclk_edge <= ~mclk_edge;
    bclk_p <= bclk_out;
    pin_p <= out_clk_pin;
    pfs_p <= pfs_out;
    n_edge <= n_edge + int'(mclk_edge);
    n_bt <= n_bt + int'(bclk_out != bclk_p);
    n_pt <= n_pt + int'(out_clk_pin != pin_p);
    fs_cnt <= (pfs_out && !pfs_p) ? 0 : fs_cnt + int'(mclk_edge);
    if (pfs_out && !pfs_p) begin
      fs_len <= fs_cnt;
    end
    if (cyc == 60000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts may be off by one edge since sampling is not aligned to them
  task automatic near(input int got, input int exp, input int tol);
    chk({31'h0, got - exp <= tol && exp - got <= tol}, 32'h1);
  endtask : near

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic meas(input int n);
    int e0, b0, p0;
    e0 = n_edge;
    b0 = n_bt;
    p0 = n_pt;
    repeat (n) @(posedge sys_clk);
    de = n_edge - e0;
    db = n_bt - b0;
    dp = n_pt - p0;
  endtask : meas

  initial begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {h_run, h_fmt, h_l, h_r} = '0;
    h_wl = 6'h10;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    bus(0, asr_pkg::ADDR_SRATE, 0);
    chk(q, 32'h0000_0020);
    bus(0, asr_pkg::ADDR_CTRL, 0);
    chk(q, 32'h0000_0000);
    bus(1, asr_pkg::ADDR_SRATE, 32'h0000_01FF);
    bus(0, asr_pkg::ADDR_SRATE, 0);
    chk(q, 32'h0000_00FF);
    bus(0, 5'h1C, 0);
    chk(q, 32'h0000_0000);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      bus(1, asr_pkg::ADDR_SRATE, {23'h0, srv[i]});
      bus(0, asr_pkg::ADDR_STAT, 0);
      chk(q & 32'h0000_3FFE, 32'((i != 5 && i != 6) << 13 | ft[i] << 11
        | adc_l[ft[i]] << 6 | dac_l[ft[i]] << 1));
    end
    $display("test latency done");
    bus(1, asr_pkg::ADDR_CTRL, 32'h0000_0002);
    meas(400);
    near(db, 0, 0);
    chk({31'h0, dout}, 32'h0);
    bus(1, asr_pkg::ADDR_SRATE, 32'h0000_0001);
    bus(1, asr_pkg::ADDR_CTRL, 32'h0000_0007);
    chk({29'h0, bclk_oe, pfs_oe, rfs_oe}, 32'h7);
    meas(400);
    near(db, de, 1);
    near(dp, de, 1);
    repeat (2500) @(posedge sys_clk);
    near(fs_len, 500, 2);
    bus(1, asr_pkg::ADDR_SRATE, 32'h0000_0081);
    meas(400);
    near(dp, de / 2, 1);
    near(db, de, 1);
    bus(1, asr_pkg::ADDR_SRATE, 32'h0000_0041);
    repeat (5000) @(posedge sys_clk);
    near(fs_len, 1000, 4);
    bus(1, asr_pkg::ADDR_SRATE, 32'h0000_0023);
    repeat (3000) @(posedge sys_clk);
    near(fs_len, 544, 2);
    bus(1, asr_pkg::ADDR_SRATE, 32'h0000_0000);
    meas(400);
    near(db, de / 4, 1);
    repeat (3000) @(posedge sys_clk);
    near(fs_len, 512, 8);
    $display("test master clocks done");
    for (int i = 0; i < 5; i++) begin
      h_fmt <= 2'(fm[i]);
      h_wl <= 6'(nb[i]);
      h_l <= 32'hA5C3_9E71 + i;
      h_r <= 32'h5A3C_61E8;
      bus(1, asr_pkg::ADDR_REC_L, 32'hC1F0_E512 ^ i);
      bus(1, asr_pkg::ADDR_REC_R, 32'h3B6D_9A45);
      bus(1, asr_pkg::ADDR_CTRL, 32'(1 | fm[i] << 2 | wc[i] << 4));
      h_run <= 1'b1;
      repeat (2600) @(posedge sys_clk);
      chk({30'h0, bclk_oe, pfs_oe}, 32'h0);
      ev = {32'h0, 32'hFFFF_FFFF} >> (32 - nb[i]);
      bus(0, asr_pkg::ADDR_PB_L, 0);
      chk(q, h_l & ev[31:0]);
      bus(0, asr_pkg::ADDR_PB_R, 0);
      chk(q, h_r & ev[31:0]);
      ev = u_host.frame_bits(h_fmt, h_wl, 32'hC1F0_E512 ^ i, 32'h3B6D_9A45);
      chk(h_cap[31:0], ev[31:0]);
      chk(h_cap[63:32], ev[63:32]);
      h_run <= 1'b0;
      bus(1, asr_pkg::ADDR_CTRL, 32'h0000_0000);
    end
    $display("test slave framing done");
    close_out();
  end
endmodule : tb_top
